// >>> hdl/rplt_timing.sv
// Resonant-mode switching period limit and gate edge timing generator.
//
// Behaviour
// - The 12-bit longest cycle limit has its upper eight bits in the upper period register.
// - The lower four bits of that limit come from bits 7 to 4 of the lower period register.
// - The limit is always used as the combined 12-bit value, never one part alone.
// - One limit count stands for 5 ns of switching cycle.
// - The primary output falls at a set 8-bit offset from mid-cycle, 5 ns per count.
// - The secondary output rises its 8-bit register value x 5 ns after the cycle start.
// - Resonant timing runs only while the 6-bit frequency field holds all ones.
`timescale 1ns/1ps

module rplt_timing
    import rplt_pkg::*;
#(
    parameter int PERIOD_W = 12
) (
    // Clock, reset and clock enable.
    input  wire logic                clk,
    input  wire logic                rstn,
    input  wire logic                ce,
    // Register port.
    input  wire logic [7:0]          regAddr,
    input  wire logic                regWrEn,
    input  wire logic [7:0]          regWrData,
    input  wire logic                regRdEn,
    output logic      [7:0]          regRdData,
    // Feedback loop command.
    input  wire logic                loopActive,
    input  wire logic [PERIOD_W-1:0] cmdPeriod,
    // Gate outputs and status.
    output logic                     primary_gate_out,
    output logic                     secondary_gate_out,
    output logic                     cycleStart,
    output logic      [PERIOD_W-1:0] activePeriod
);

    // Elaboration check: the limit is exactly one byte plus one nibble.
    if (PERIOD_W != 12) begin : g_bad_width
        $error("PERIOD_W must be 12");
    end

    localparam int PH_W = PERIOD_W + 2;
    localparam logic signed [PH_W-1:0] STEP = PH_W'(STEP_COUNTS);

    ////////////////////////////////////////////////////////////////////////////////
    // Registers.

    logic [7:0] freqSet_q;
    logic [7:0] firstRise_q;
    logic [7:0] periodUpper_q;
    logic [7:0] firstFall_q;
    logic [7:0] periodLower_q;
    logic [7:0] secondRise_q;

    // Register writes; all bits including reserved ones are kept.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            freqSet_q     <= RST_FREQ_SET;
            firstRise_q   <= RST_DELAY;
            periodUpper_q <= RST_PERIOD_UPPER;
            firstFall_q   <= RST_DELAY;
            periodLower_q <= RST_PERIOD_LOWER;
            secondRise_q  <= RST_DELAY;
        end else if (ce && regWrEn) begin
            case (regAddr)
                OFS_FREQ_SET:     freqSet_q     <= regWrData;
                OFS_FIRST_RISE:   firstRise_q   <= regWrData;
                OFS_PERIOD_UPPER: periodUpper_q <= regWrData;
                OFS_FIRST_FALL:   firstFall_q   <= regWrData;
                OFS_PERIOD_LOWER: periodLower_q <= regWrData;
                OFS_SECOND_RISE:  secondRise_q  <= regWrData;
                default: ;
            endcase
        end
    end

    // Registered read data; unmapped offsets read as zero.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            regRdData <= 8'h00;
        end else if (ce && regRdEn) begin
            case (regAddr)
                OFS_FREQ_SET:     regRdData <= freqSet_q;
                OFS_FIRST_RISE:   regRdData <= firstRise_q;
                OFS_PERIOD_UPPER: regRdData <= periodUpper_q;
                OFS_FIRST_FALL:   regRdData <= firstFall_q;
                OFS_PERIOD_LOWER: regRdData <= periodLower_q;
                OFS_SECOND_RISE:  regRdData <= secondRise_q;
                default:          regRdData <= 8'h00;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Period limit and clamp.

    logic [PERIOD_W-1:0] maxLimit;
    logic [PERIOD_W-1:0] periodSel;
    logic                resonant;

    // The limit is only ever used as the full byte plus nibble value.
    assign maxLimit  = {periodUpper_q,
                        periodLower_q[LOWER_NIBBLE_MSB:LOWER_NIBBLE_LSB]};
    // A regulating loop may shorten the period but never stretch it past the limit.
    assign periodSel = (loopActive && (cmdPeriod < maxLimit)) ?
                       cmdPeriod : maxLimit;
    assign resonant  = (freqSet_q[FREQ_FIELD_MSB:0] == RESONANT_CODE);

    ////////////////////////////////////////////////////////////////////////////////
    // Cycle generator.

    rplt_state_e              state_q;
    logic signed [PH_W-1:0]   phase_q;
    logic signed [PH_W-1:0]   nextPhase;
    logic signed [PH_W-1:0]   fallPoint_q;
    logic signed [PH_W-1:0]   fallCalc;
    logic signed [PH_W-1:0]   risePoint_q;
    logic                     wrap;

    // Mode state follows the frequency field.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_q <= ST_OFF;
        end else if (ce) begin
            case (state_q)
                ST_OFF:  state_q <= resonant ? ST_RUN : ST_OFF;
                ST_RUN:  state_q <= resonant ? ST_RUN : ST_OFF;
                default: state_q <= ST_OFF;
            endcase
        end
    end

    // Phase counts in 5 ns units and advances one clock period per cycle.
    assign nextPhase = phase_q + STEP;
    assign wrap      = (state_q != ST_RUN) || (nextPhase >= $signed({2'b00, activePeriod}));
    // Mid-cycle plus the sign-extended code gives trailing or leading fall.
    assign fallCalc  = $signed({3'b000, periodSel[PERIOD_W-1:1]})
                     + PH_W'($signed(firstFall_q));

    // Phase and per-cycle timing, latched at each cycle start.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            phase_q      <= '0;
            activePeriod <= '0;
            fallPoint_q  <= '0;
            risePoint_q  <= '0;
            cycleStart   <= 1'b0;
        end else if (ce) begin
            cycleStart <= wrap && resonant;
            if (wrap) begin
                phase_q      <= '0;
                activePeriod <= periodSel;
                fallPoint_q  <= fallCalc;
                risePoint_q  <= $signed({{(PH_W-8){1'b0}}, secondRise_q});
            end else begin
                phase_q <= nextPhase;
            end
        end
    end

    // Gate outputs, low whenever resonant mode is not running.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            primary_gate_out   <= 1'b0;
            secondary_gate_out <= 1'b0;
        end else if (ce) begin
            primary_gate_out   <= (state_q == ST_RUN) && (phase_q < fallPoint_q);
            secondary_gate_out <= (state_q == ST_RUN) && (phase_q >= risePoint_q);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Assertions.

    sequence s_wrUpper;
        ce && regWrEn && (regAddr == OFS_PERIOD_UPPER);
    endsequence

    sequence s_wrLower;
        ce && regWrEn && (regAddr == OFS_PERIOD_LOWER);
    endsequence

    sequence s_leaveMode;
        ce && !resonant ##1 ce;
    endsequence

    property p_limitUpper;
        @(posedge clk) disable iff (!rstn)
        s_wrUpper |=> (maxLimit[11:4] == $past(regWrData));
    endproperty
    a_limitUpper: assert property (p_limitUpper)
        else $error("upper limit byte not applied");

    property p_limitLower;
        @(posedge clk) disable iff (!rstn)
        s_wrLower |=> (maxLimit[3:0] == $past(regWrData[7:4]));
    endproperty
    a_limitLower: assert property (p_limitLower)
        else $error("lower limit nibble not applied");

    property p_periodBound;
        @(posedge clk) disable iff (!rstn)
        (ce && wrap) |=> (activePeriod <= $past(maxLimit));
    endproperty
    a_periodBound: assert property (p_periodBound)
        else $error("period above combined limit");

    property p_phaseStep;
        @(posedge clk) disable iff (!rstn)
        (ce && !wrap) |=> (phase_q == $past(phase_q) + STEP);
    endproperty
    a_phaseStep: assert property (p_phaseStep)
        else $error("phase did not advance 50 ns");

    property p_primaryFall;
        @(posedge clk) disable iff (!rstn)
        (ce && state_q == ST_RUN && phase_q >= fallPoint_q) |=> !primary_gate_out;
    endproperty
    a_primaryFall: assert property (p_primaryFall)
        else $error("primary output late to fall");

    property p_fallOffset;
        @(posedge clk) disable iff (!rstn)
        (ce && wrap && firstFall_q[7]) |=> (fallPoint_q < $signed({3'b000, activePeriod[11:1]}));
    endproperty
    a_fallOffset: assert property (p_fallOffset)
        else $error("leading code did not advance fall");

    property p_clamp;
        @(posedge clk) disable iff (!rstn)
        (loopActive && cmdPeriod > maxLimit) |-> (periodSel == maxLimit);
    endproperty
    a_clamp: assert property (p_clamp)
        else $error("commanded period not clamped");

    property p_secondRise;
        @(posedge clk) disable iff (!rstn)
        (ce && state_q == ST_RUN && phase_q >= risePoint_q) |=> secondary_gate_out;
    endproperty
    a_secondRise: assert property (p_secondRise)
        else $error("secondary output did not rise");

    property p_modeOff;
        @(posedge clk) disable iff (!rstn)
        s_leaveMode |=> (!primary_gate_out && !secondary_gate_out);
    endproperty
    a_modeOff: assert property (p_modeOff)
        else $error("outputs active outside resonant mode");

endmodule // rplt_timing

// >>> inc/rplt_pkg.sv
// Constants for the resonant-mode period limit and output edge timing block.
package rplt_pkg;

    // Register offsets on the device register port.
    localparam logic [7:0] OFS_FREQ_SET       = 8'h40;
    localparam logic [7:0] OFS_FIRST_RISE     = 8'h41;
    localparam logic [7:0] OFS_PERIOD_UPPER   = 8'h42;
    localparam logic [7:0] OFS_FIRST_FALL     = 8'h43;
    localparam logic [7:0] OFS_PERIOD_LOWER   = 8'h44;
    localparam logic [7:0] OFS_SECOND_RISE    = 8'h45;

    // Field positions and codes.
    localparam int         FREQ_FIELD_MSB     = 5;
    localparam int         LOWER_NIBBLE_MSB   = 7;
    localparam int         LOWER_NIBBLE_LSB   = 4;
    localparam logic [5:0] RESONANT_CODE      = 6'h3F;

    // Reset values of the registers.
    localparam logic [7:0] RST_FREQ_SET       = 8'h00;
    localparam logic [7:0] RST_DELAY          = 8'h00;
    localparam logic [7:0] RST_PERIOD_UPPER   = 8'h00;
    localparam logic [7:0] RST_PERIOD_LOWER   = 8'h00;

    // Timing: one limit count is 5 ns, the clock period is 50 ns.
    localparam int         COUNT_NS           = 5;
    localparam int         CLK_PERIOD_NS      = 50;
    localparam int         STEP_COUNTS        = CLK_PERIOD_NS / COUNT_NS;

    // Run state of the switching cycle generator.
    typedef enum logic [1:0] {
        ST_OFF = 2'b01,
        ST_RUN = 2'b10
    } rplt_state_e;

endpackage

// >>> testbench/rplt_gate_stage.sv
// Gate drive model of the resonant stage: counts gate high time per switching cycle.
`timescale 1ns/1ps

module rplt_gate_stage (
    // Clock and reset.
    input  wire logic       clk,
    input  wire logic       rstn,
    // Gate outputs and cycle start mark of the controller.
    input  wire logic       primary_gate_out,
    input  wire logic       secondary_gate_out,
    input  wire logic       cycleStart,
    // Measured figures of the last whole cycle, in clock cycles.
    output logic      [7:0] priHigh,
    output logic      [7:0] secHigh,
    output logic      [7:0] cycLen
);
    logic [7:0] priAcc;
    logic [7:0] secAcc;
    logic [7:0] lenAcc;

    // Each window runs from one cycle start mark to the next, so phase offset is harmless.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            {priAcc, secAcc, lenAcc, priHigh, secHigh, cycLen} <= '0;
        end else if (cycleStart) begin
            priHigh <= priAcc;
            secHigh <= secAcc;
            cycLen  <= lenAcc;
            priAcc  <= {7'h00, primary_gate_out};
            secAcc  <= {7'h00, secondary_gate_out};
            lenAcc  <= 8'h01;
        end else begin
            priAcc  <= priAcc + {7'h00, primary_gate_out};
            secAcc  <= secAcc + {7'h00, secondary_gate_out};
            lenAcc  <= lenAcc + 8'h01;
        end
    end
endmodule // rplt_gate_stage

// >>> testbench/test_rplt_timing.sv
// Self-checking bench for the resonant period limit and gate timing block.
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin fails++; \
    $display("mismatch at %0t: got %h expected %h", $time, a, b); end end

module test_rplt_timing
    import rplt_pkg::*;
;

    logic        clk, rstn, ce, regWrEn, regRdEn, loopActive;
    logic [7:0]  regAddr, regWrData, regRdData, priHigh, secHigh, cycLen;
    logic [11:0] cmdPeriod, activePeriod;
    logic        primary_gate_out, secondary_gate_out, cycleStart;
    int          fails, n_tests, cycles;

    rplt_timing rplt_timing_i (.clk(clk), .rstn(rstn), .ce(ce), .regAddr(regAddr),
        .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData),
        .loopActive(loopActive), .cmdPeriod(cmdPeriod), .primary_gate_out(primary_gate_out),
        .secondary_gate_out(secondary_gate_out), .cycleStart(cycleStart),
        .activePeriod(activePeriod));

    rplt_gate_stage rplt_gate_stage_i (.clk(clk), .rstn(rstn),
        .primary_gate_out(primary_gate_out), .secondary_gate_out(secondary_gate_out),
        .cycleStart(cycleStart), .priHigh(priHigh), .secHigh(secHigh), .cycLen(cycLen));

    ////////////////////////////////////////////////////////////////////////////////
    // Clock of 50 ns and a cycle ceiling that cuts a hang short.
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            fails++;
            final_report();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Register access tasks, driven on the falling edge.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        regAddr   = a;
        regWrData = d;
        regWrEn   = 1'b1;
        @(negedge clk);
        regWrEn   = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        regAddr = a;
        regRdEn = 1'b1;
        @(negedge clk);
        regRdEn = 1'b0;
        d       = regRdData;
    endtask

    // Waits for a number of cycle start marks, each under a bounded count.
    task automatic starts(input int n);
        int k;
        repeat (n) begin
            k = 0;
            do begin
                @(negedge clk);
                k++;
            end while (!cycleStart && k < 300);
            `CHK(cycleStart, 1'b1)
        end
    endtask

    // Checks the measured cycle against expected figures. The gate model's window lags the
    // cycle by one sample and a write may land on a wrap edge, so five starts are let pass
    // before the held figures belong wholly to the new settings.
    task automatic meas(input logic [11:0] p, input logic [7:0] pr, input logic [7:0] sc,
                        input logic [7:0] ln);
        starts(5);
        `CHK(activePeriod, p)
        `CHK(priHigh, pr)
        `CHK(secHigh, sc)
        `CHK(cycLen, ln)
    endtask

    task automatic final_report();
        if (fails == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence.
    initial begin
        logic [7:0] d;
        {rstn, regWrEn, regRdEn, loopActive} = '0;
        ce = 1'b1;
        regAddr = 8'h00;
        regWrData = 8'h00;
        cmdPeriod = 12'h000;
        repeat (2) @(negedge clk);
        rstn = 1'b1;
        // Reset values and read back of the limit registers and the first fall and second rise delay registers.
        for (int a = 8'h42; a <= 8'h45; a++) begin
            rd(a[7:0], d);
            `CHK(d, 8'h00)
            wr(a[7:0], 8'hA5 + a[7:0]);
            rd(a[7:0], d);
            `CHK(d, 8'hA5 + a[7:0])
        end
        rd(8'h50, d);
        `CHK(d, 8'h00)
        // A write while the clock enable is low must leave the register alone.
        ce = 1'b0;
        wr(OFS_PERIOD_UPPER, 8'h11);
        ce = 1'b1;
        rd(OFS_PERIOD_UPPER, d);
        `CHK(d, 8'hE7)
        // Limit 40 counts is 200 ns, four clocks; rise delay 15.
        wr(OFS_PERIOD_UPPER, 8'h02);
        wr(OFS_PERIOD_LOWER, 8'h8C);
        wr(OFS_FIRST_FALL, 8'h00);
        wr(OFS_SECOND_RISE, 8'h0F);
        wr(OFS_FREQ_SET, 8'h3F);
        meas(12'd40, 8'd2, 8'd2, 8'd4);
        wr(OFS_SECOND_RISE, 8'h00);
        meas(12'd40, 8'd2, 8'd4, 8'd4);
        wr(OFS_FIRST_FALL, 8'h0A);
        meas(12'd40, 8'd3, 8'd4, 8'd4);
        wr(OFS_FIRST_FALL, 8'h80);
        meas(12'd40, 8'd0, 8'd4, 8'd4);
        wr(OFS_FIRST_FALL, 8'hFF);
        meas(12'd40, 8'd2, 8'd4, 8'd4);
        // Loop command inside and beyond the limit.
        loopActive = 1'b1;
        cmdPeriod  = 12'd20;
        meas(12'd20, 8'd1, 8'd2, 8'd2);
        cmdPeriod  = 12'd100;
        meas(12'd40, 8'd2, 8'd4, 8'd4);
        // Upper byte 0x05 with only reserved low bits set gives 80 counts, eight clocks.
        loopActive = 1'b0;
        wr(OFS_PERIOD_UPPER, 8'h05);
        wr(OFS_PERIOD_LOWER, 8'h03);
        meas(12'd80, 8'd4, 8'd8, 8'd8);
        // Leaving resonant mode drops both gates.
        wr(OFS_FREQ_SET, 8'h3E);
        repeat (3) @(negedge clk);
        `CHK({primary_gate_out, secondary_gate_out}, 2'b00)
        final_report();
    end
endmodule // test_rplt_timing
